// ===== verilog/rsr_defines.svh
/*
  Constants for the reset and stop-recovery controller: register byte
  addresses, field positions, reset values and timing counts.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

// Register byte addresses (12-bit register file space)
`define RSR_ADDR_CAUSE 12'hff0
`define RSR_ADDR_CTRL 12'hff4
`define RSR_ADDR_DBG 12'hff8
`define RSR_ADDR_CFG 12'hffc

// Cause status field positions
`define RSR_CAUSE_POR 7
`define RSR_CAUSE_STOP 6
`define RSR_CAUSE_WDT 5
`define RSR_CAUSE_EXT 4
`define RSR_CAUSE_DBG 3
`define RSR_CAUSE_RESET 8'h80

// Reset vector location fetched by the core after release
`define RSR_RESET_VECTOR 16'h0002

// Control register fields (software requests stop mode, selects clock)
`define RSR_CTRL_STOP 0
`define RSR_CTRL_XTAL_SEL 1
`define RSR_CTRL_RESET 8'h00

// Debugger control: bit zero requests a reset
`define RSR_DBG_RST 0

// Config register: wake pin enable mask reset value
`define RSR_CFG_RESET 8'h00

// Timing
`define RSR_IPO_START_NS 4000
`define RSR_CLK_NS 8
`define RSR_HOLD_SHORT 66
`define RSR_HOLD_XTAL 5000
`define RSR_PIN_MIN 3

// AXI response codes
`define RSR_RESP_OKAY 2'b00
`define RSR_RESP_SLVERR 2'b10

`endif

// ===== verilog/rsr_pkg.sv
/*
  Types shared by the reset and stop-recovery controller.
  Assumes nothing of its surroundings.
*/
package rsr_pkg;
  typedef enum logic [2:0] {
    RSR_RUN,
    RSR_START,
    RSR_HOLD,
    RSR_PINWAIT
  } rsr_state_t;
endpackage : rsr_pkg

// ===== verilog/rsr_pin_filter.sv
/*
  Synchroniser and glitch filter for the external reset pin.
  Assumes an asynchronous active-low pin; output is a clean level.
*/
`timescale 1ns/100ps
`include "rsr_defines.svh"

module rsr_pin_filter #(
  parameter int MIN_CYCLES = `RSR_PIN_MIN
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_n,
  output logic asserted
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [3:0] run_q;

  // Three-stage synchroniser; only stage two and three are compared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Count agreed-low cycles; short pulses never reach the threshold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 4'h0;
    end else if (!s2_q && !s3_q) begin
      if (run_q < 4'(MIN_CYCLES)) run_q <= run_q + 4'h1;
    end else begin
      run_q <= 4'h0;
    end
  end

  assign asserted = (run_q >= 4'(MIN_CYCLES));
endmodule : rsr_pin_filter

// ===== verilog/rsr_controller.sv
/*
  Reset and stop-mode recovery sequencer with an AXI4-Lite register slave.
  Merges power-on, brown-out, watchdog, pin and debugger resets and stop
  wake sources, counts the hold period, holds the core and, on system
  resets only, holds peripherals and forces the GPIO pins to safe inputs.
  Assumes supply monitor, watchdog and option bits are synchronous to aclk.

  // Notes on behaviour
  // - Power-on, brown-out, pin, debugger start reset
  // - Watchdog resets only when option selects reset
  // - Pin counts only with alternate function enabled
  // - Debugger bit zero write begins reset
  // - Stop mode wakes on watchdog or pin
  // - Stop recovery holds core like reset
  // - Hold 66 oscillator cycles after startup
  // - Crystal enabled extends hold to 5000
  // - Oscillator start-up interval precedes counting
  // - Supply reset counts after supply good
  // - Pin still low extends reset until release
  // - Reset forces GPIO inputs, pull-ups off
  // - Core, peripherals idle; oscillators keep running
  // - Defined registers reload; others undefined
  // - Core fetches vector at 0002H/0003H
  // - Reset selects internal oscillator as clock
  // - Stop recovery touches watchdog, oscillator only
  // - Debugger reset spares debugger, self-clears, flags power-on
  // - Pin pulses under three clocks ignored
*/
`timescale 1ns/100ps
`include "rsr_defines.svh"

module rsr_controller #(
  parameter int GPIO_W = 8,
  parameter int HOLD_XTAL = `RSR_HOLD_XTAL,
  parameter int HOLD_SHORT = `RSR_HOLD_SHORT,
  parameter int START_NS = `RSR_IPO_START_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset sources
  input wire logic supply_good,
  input wire logic brown_out_detector,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_select_option,
  input wire logic xtal_enable_option,
  input wire logic ext_reset_pin_n,
  input wire logic ext_reset_alt_en,
  input wire logic [GPIO_W-1:0] gpio_in,
  // Reset outputs
  output logic core_reset_n,
  output logic periph_reset_n,
  output logic ctrl_regs_reset_n,
  output logic wdt_osc_regs_reset_n,
  output logic gpio_force_input,
  output logic gpio_pullup_off,
  output logic ext_reset_pin_oe_n,
  output logic sys_clk_sel_ipo,
  output logic [15:0] reset_vector_addr
);
  localparam int START_CYC = (START_NS + `RSR_CLK_NS - 1) / `RSR_CLK_NS;
  localparam int CNT_W = 14;

  logic pin_asserted;
  logic pin_src;
  logic sys_drive;
  logic supply_bad;
  logic sys_req;
  logic stop_req;
  logic dbg_req_q;
  logic stop_mode_q;
  logic xtal_sel_q;
  logic [GPIO_W-1:0] wake_en_q;
  logic [GPIO_W-1:0] gpio_last_q;
  logic [7:0] cause_q;
  logic is_stop_q;
  logic [CNT_W-1:0] cnt_q;
  rsr_pkg::rsr_state_t state_q;
  logic in_reset;
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic wr_ok;

  // Hold length chosen from crystal option
  function automatic logic [CNT_W-1:0] hold_len(input logic xtal);
    hold_len = xtal ? CNT_W'(HOLD_XTAL - 1) : CNT_W'(HOLD_SHORT - 1);
  endfunction : hold_len

  rsr_pin_filter u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_n(ext_reset_pin_n),
    .asserted(pin_asserted)
  );

  // Source merge; supply faults dominate everything
  assign supply_bad = !supply_good || brown_out_detector;
  // Own drive of the pin reads back low; it must not restart the count
  assign pin_src = pin_asserted && ext_reset_alt_en
    && !(in_reset && !is_stop_q);
  assign sys_req = supply_bad || pin_src || dbg_req_q
    || (watchdog_timeout && watchdog_reset_select_option);
  assign stop_req = stop_mode_q && (watchdog_timeout
    || |((gpio_in ^ gpio_last_q) & wake_en_q));

  assign in_reset = (state_q != rsr_pkg::RSR_RUN);

  // Pin drive stops when the hold ends, so the pin wait sees only an
  // outside pull on the wired-AND line
  assign sys_drive = in_reset && !is_stop_q
    && (state_q != rsr_pkg::RSR_PINWAIT);

  // Sequencer: start-up wait, hold count, optional pin wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= rsr_pkg::RSR_START;
      // Leaving reset also waits out the oscillator start-up
      cnt_q <= CNT_W'(START_CYC - 1);
      is_stop_q <= 1'b0;
    end else if (sys_req) begin
      state_q <= rsr_pkg::RSR_START;
      cnt_q <= CNT_W'(START_CYC - 1);
      is_stop_q <= 1'b0;
    end else if (stop_req && !in_reset) begin
      state_q <= rsr_pkg::RSR_START;
      cnt_q <= CNT_W'(START_CYC - 1);
      is_stop_q <= 1'b1;
    end else begin
      unique case (state_q)
        rsr_pkg::RSR_RUN: ;
        rsr_pkg::RSR_START: begin
          if (cnt_q == '0) begin
            state_q <= rsr_pkg::RSR_HOLD;
            cnt_q <= hold_len(xtal_enable_option);
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        rsr_pkg::RSR_HOLD: begin
          if (cnt_q == '0) begin
            state_q <= rsr_pkg::RSR_PINWAIT;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        rsr_pkg::RSR_PINWAIT: begin
          // Filtered level: stays held until the pin is let go; filter
          // lag adds a few cycles after own drive ends
          if (!(pin_asserted && ext_reset_alt_en)) begin
            state_q <= rsr_pkg::RSR_RUN;
          end
        end
        default: state_q <= rsr_pkg::RSR_START;
      endcase
    end
  end

  // Reset outputs; stop recovery spares the general control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reset_n <= 1'b0;
      periph_reset_n <= 1'b0;
      ctrl_regs_reset_n <= 1'b0;
      wdt_osc_regs_reset_n <= 1'b0;
      gpio_force_input <= 1'b1;
      gpio_pullup_off <= 1'b1;
      ext_reset_pin_oe_n <= 1'b1;
    end else begin
      core_reset_n <= !in_reset;
      periph_reset_n <= !(in_reset && !is_stop_q);
      ctrl_regs_reset_n <= !(in_reset && !is_stop_q);
      wdt_osc_regs_reset_n <= !in_reset;
      gpio_force_input <= in_reset && !is_stop_q;
      gpio_pullup_off <= in_reset && !is_stop_q;
      // Open-drain indicator: enable low means pulling the pin low
      ext_reset_pin_oe_n <= !sys_drive;
    end
  end

  // Vector address held constant for the core's first fetch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_vector_addr <= `RSR_RESET_VECTOR;
    end else begin
      reset_vector_addr <= `RSR_RESET_VECTOR;
    end
  end

  // Clock select returns to the internal oscillator on any reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_sel_ipo <= 1'b1;
      xtal_sel_q <= 1'b0;
    end else if (in_reset) begin
      sys_clk_sel_ipo <= 1'b1;
      xtal_sel_q <= 1'b0;
    end else begin
      if (wr_ok && aw_addr_q == `RSR_ADDR_CTRL && w_strb_q[0]) begin
        xtal_sel_q <= w_data_q[`RSR_CTRL_XTAL_SEL];
      end
      sys_clk_sel_ipo <= !xtal_sel_q;
    end
  end

  // Stop mode flag, wake enables, pin history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_mode_q <= 1'b0;
      wake_en_q <= '0;
      gpio_last_q <= '0;
    end else begin
      gpio_last_q <= gpio_in;
      if (in_reset) begin
        stop_mode_q <= 1'b0;
        if (!is_stop_q) wake_en_q <= '0;
      end else if (wr_ok && w_strb_q[0]) begin
        if (aw_addr_q == `RSR_ADDR_CTRL) begin
          stop_mode_q <= w_data_q[`RSR_CTRL_STOP];
        end
        if (aw_addr_q == `RSR_ADDR_CFG) begin
          wake_en_q <= w_data_q[GPIO_W-1:0];
        end
      end
    end
  end

  // Debugger request self-clears once reset begins; set wins at start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_req_q <= 1'b0;
    end else if (wr_ok && aw_addr_q == `RSR_ADDR_DBG && w_strb_q[0]
                 && w_data_q[`RSR_DBG_RST]) begin
      dbg_req_q <= 1'b1;
    end else if (in_reset) begin
      dbg_req_q <= 1'b0;
    end
  end

  // Cause flags: latched when a reset starts from run, kept after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= `RSR_CAUSE_RESET;
    end else if (sys_req && !in_reset) begin
      cause_q <= '0;
      cause_q[`RSR_CAUSE_POR] <= supply_bad || dbg_req_q;
      cause_q[`RSR_CAUSE_WDT] <= watchdog_timeout
        && watchdog_reset_select_option;
      cause_q[`RSR_CAUSE_EXT] <= pin_src;
      cause_q[`RSR_CAUSE_DBG] <= dbg_req_q;
    end else if (stop_req && !in_reset) begin
      cause_q <= '0;
      cause_q[`RSR_CAUSE_STOP] <= 1'b1;
      cause_q[`RSR_CAUSE_WDT] <= watchdog_timeout;
    end else if (in_reset && supply_bad) begin
      cause_q[`RSR_CAUSE_POR] <= 1'b1;
    end
  end

  // AXI write: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ok = wr_fire && (aw_addr_q == `RSR_ADDR_CTRL
    || aw_addr_q == `RSR_ADDR_DBG || aw_addr_q == `RSR_ADDR_CFG
    || aw_addr_q == `RSR_ADDR_CAUSE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RSR_RESP_OKAY : `RSR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read: one cycle to data; unmapped answers SLVERR with zero
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RSR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RSR_RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `RSR_ADDR_CAUSE: s_axi_rdata <= {24'h0, cause_q};
        `RSR_ADDR_CTRL: s_axi_rdata <= {30'h0, xtal_sel_q, stop_mode_q};
        `RSR_ADDR_DBG: s_axi_rdata <= {31'h0, dbg_req_q};
        `RSR_ADDR_CFG: s_axi_rdata <= 32'(wake_en_q);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `RSR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : rsr_controller

// ===== tb/rsr_monitor.sv
/*
  Checker for the reset sequencer outputs, bound into rsr_controller.
  Assumes one clock domain and the sequencer's registered outputs.
*/
`timescale 1ns/100ps
module rsr_monitor #(
  parameter int HOLD_XTAL = 5000,
  parameter int HOLD_SHORT = 66
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supply_good,
  input wire logic brown_out_detector,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_select_option,
  input wire logic xtal_enable_option,
  input wire logic ext_reset_pin_n,
  input wire logic ext_reset_alt_en,
  input wire logic ext_reset_pin_oe_n,
  input wire logic core_reset_n,
  input wire logic periph_reset_n,
  input wire logic gpio_force_input,
  input wire logic gpio_pullup_off,
  input wire logic sys_clk_sel_ipo,
  input wire logic [15:0] reset_vector_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int low_q;
  // Cycles the core has spent in reset; restarts count only upward
  always_ff @(posedge aclk) begin
    if (!aresetn || core_reset_n) low_q <= 0;
    else low_q <= low_q + 1;
  end
  a_hold_len: assert property ($rose(core_reset_n) |->
    low_q >= (xtal_enable_option ? HOLD_XTAL : HOLD_SHORT))
    else $error("core released before hold period");
  a_vector_fixed: assert property (reset_vector_addr == 16'h0002)
    else $error("reset vector address wrong");
  a_gpio_safe: assert property (!periph_reset_n |->
    gpio_force_input && gpio_pullup_off) else $error("gpio not safe");
  a_periph_core: assert property (!periph_reset_n |-> !core_reset_n)
    else $error("core runs while peripherals held");
  a_brownout_start: assert property (brown_out_detector |->
    ##[1:3] !core_reset_n) else $error("brown-out ignored");
  a_supply_hold: assert property (!supply_good [*3] |->
    !core_reset_n) else $error("core runs on low supply");
  a_wdt_reset: assert property (watchdog_timeout &&
    watchdog_reset_select_option |-> ##[1:3] !core_reset_n)
    else $error("watchdog reset ignored");
  a_pin_reset: assert property ((ext_reset_alt_en &&
    ext_reset_pin_oe_n && !ext_reset_pin_n) [*4] |-> ##[0:6] !core_reset_n)
    else $error("pin reset ignored");
  a_clk_ipo: assert property ($rose(core_reset_n) |->
    sys_clk_sel_ipo) else $error("clock not internal after reset");
  // Main scenarios reached
  c_xtal: cover property ($rose(core_reset_n) && xtal_enable_option);
  c_stop: cover property ($fell(core_reset_n) && periph_reset_n);
  c_pin: cover property (ext_reset_alt_en && !ext_reset_pin_n);
endmodule : rsr_monitor

bind rsr_controller rsr_monitor #(.HOLD_XTAL(HOLD_XTAL),
  .HOLD_SHORT(HOLD_SHORT)) u_mon (.aclk, .aresetn, .supply_good,
  .brown_out_detector, .watchdog_timeout, .watchdog_reset_select_option,
  .xtal_enable_option, .ext_reset_pin_n, .ext_reset_alt_en,
  .ext_reset_pin_oe_n, .core_reset_n, .periph_reset_n, .gpio_force_input,
  .gpio_pullup_off, .sys_clk_sel_ipo, .reset_vector_addr);

// ===== tb/rsr_far_model.sv
/*
  Far side: open-drain reset pin with pull-up, and a core that loads
  the reset vector on release. Assumes the bench pulls the pin.
*/
`timescale 1ns/100ps
module rsr_far_model (
  input wire logic aclk,
  input wire logic pull_low,
  input wire logic ext_reset_pin_oe_n,
  input wire logic core_reset_n,
  input wire logic [15:0] reset_vector_addr,
  output logic ext_reset_pin_n,
  output logic [15:0] fetch_addr
);
  // Wired-AND pin; pull-up gives high when nobody pulls
  assign ext_reset_pin_n = !(pull_low || !ext_reset_pin_oe_n);
  // Core idles in reset, fetches the vector once released
  always_ff @(posedge aclk) begin
    if (!core_reset_n) fetch_addr <= 16'hffff;
    else if (fetch_addr == 16'hffff) fetch_addr <= reset_vector_addr;
  end
endmodule : rsr_far_model

// ===== tb/rsr_controller_tb.sv
/*
  Bench for the reset sequencer: AXI4-Lite master, reset sources, pin.
  Assumes START_NS shortened to two cycles and HOLD_XTAL of 20.
*/
`timescale 1ns/100ps
`include "rsr_defines.svh"
module rsr_controller_tb;
  localparam int HS = 66;
  localparam int HX = 20;
  logic aclk = 0, aresetn = 0, pull_low = 0, supply_good = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic brown_out_detector = 0, watchdog_timeout = 0, ext_reset_alt_en = 0;
  logic watchdog_reset_select_option = 0, xtal_enable_option = 0;
  logic [7:0] gpio_in = 0;
  logic ext_reset_pin_n, core_reset_n, periph_reset_n, ctrl_regs_reset_n;
  logic wdt_osc_regs_reset_n, gpio_force_input, gpio_pullup_off;
  logic ext_reset_pin_oe_n, sys_clk_sel_ipo;
  logic [15:0] reset_vector_addr, fetch_addr;
  int bad_count = 0, checks = 0, seed = 3042, n, k;
  rsr_controller #(.START_NS(16), .HOLD_XTAL(HX)) u_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_good,
    .brown_out_detector, .watchdog_timeout, .watchdog_reset_select_option,
    .xtal_enable_option, .ext_reset_pin_n, .ext_reset_alt_en, .gpio_in,
    .core_reset_n, .periph_reset_n, .ctrl_regs_reset_n,
    .wdt_osc_regs_reset_n, .gpio_force_input, .gpio_pullup_off,
    .ext_reset_pin_oe_n, .sys_clk_sel_ipo, .reset_vector_addr);
  rsr_far_model u_far (.aclk, .pull_low, .ext_reset_pin_oe_n,
    .core_reset_n, .reset_vector_addr, .ext_reset_pin_n, .fetch_addr);
  // Free-running 125 MHz clock
  initial begin
    forever #4 aclk = ~aclk;
  end
  task conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask : chk
  // A wait that ran out ends the run
  task need(input logic ok);
    chk(32'(ok), 32'h1);
    if (ok !== 1'b1) conclude();
  endtask : need
  function automatic logic inwin(input int c, input int h);
    return c >= h - 2 && c <= h + 24;
  endfunction : inwin
  // Readys sampled at the falling edge; inputs only move after rising
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 100 && !b; i++) begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    // Ready stays up between writes so a next call may start at once
    need(b);
  endtask : wr
  task rdr(input logic [11:0] a, output logic [31:0] d);
    logic ar, v;
    v = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 100 && !v; i++) begin
      @(negedge aclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    need(v);
  endtask : rdr
  // Count reset cycles; a system reset forces gpio, a stop wake does not
  task rel(input logic sys);
    for (n = 0; n < 20000; n++) begin
      @(negedge aclk);
      if (n == 4) chk(32'({gpio_force_input, gpio_pullup_off,
        periph_reset_n}), sys ? 32'h6 : 32'h1);
      if (core_reset_n === 1'b1 && n > 4) break; // Outputs lag request
    end
    @(posedge aclk);
    need(core_reset_n);
  endtask : rel
  task still(input logic e);
    @(negedge aclk);
    chk(32'(core_reset_n), 32'(e));
    @(posedge aclk);
  endtask : still
  task cause(input logic [7:0] m);
    rdr(`RSR_ADDR_CAUSE, rd);
    chk(rd & 32'(m), 32'(m));
  endtask : cause
  task wdt_hit;
    watchdog_timeout <= 1'b1;
    @(posedge aclk);
    watchdog_timeout <= 1'b0;
  endtask : wdt_hit
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rel(1);
    cause(8'h80);
    chk(32'(fetch_addr), 32'h0002);
    rdr(12'h000, rd);
    chk({rd[29:0], rr}, {30'h0, `RSR_RESP_SLVERR});
    wr(`RSR_ADDR_CTRL, 32'h2);
    // Clock select follows the write an edge later; look mid-cycle
    @(negedge aclk);
    chk(32'(sys_clk_sel_ipo), 32'h0);
    @(posedge aclk);
    wr(`RSR_ADDR_DBG, 32'h1);
    rel(1);
    need(inwin(n, HS));
    chk(32'(sys_clk_sel_ipo), 32'h1);
    rdr(`RSR_ADDR_DBG, rd);
    chk(rd & 32'h1, 32'h0);
    cause(8'h80);
    rdr(`RSR_ADDR_CTRL, rd);
    chk(rd, 32'h0);
    wdt_hit();
    repeat (10) still(1);
    xtal_enable_option <= 1'b1;
    watchdog_reset_select_option <= 1'b1;
    wdt_hit();
    rel(1);
    need(inwin(n, HX));
    cause(8'h20);
    xtal_enable_option <= 1'b0;
    wdt_hit();
    repeat (30) @(posedge aclk);
    wdt_hit();
    rel(1);
    need(inwin(n, HS));
    watchdog_reset_select_option <= 1'b0;
    pull_low <= 1'b1;
    repeat (10) still(1);
    pull_low <= 1'b0;
    // Let the pin filter settle before the pin becomes a reset source
    repeat (5) @(posedge aclk);
    ext_reset_alt_en <= 1'b1;
    pull_low <= 1'b1;
    repeat (2) @(posedge aclk);
    pull_low <= 1'b0;
    repeat (10) still(1);
    pull_low <= 1'b1;
    repeat (150 + ($random(seed) & 63)) @(posedge aclk);
    still(0);
    pull_low <= 1'b0;
    rel(1);
    cause(8'h10);
    ext_reset_alt_en <= 1'b0;
    brown_out_detector <= 1'b1;
    supply_good <= 1'b0;
    repeat (2) @(posedge aclk);
    brown_out_detector <= 1'b0;
    repeat (20 + ($random(seed) & 31)) still(0);
    supply_good <= 1'b1;
    rel(1);
    need(inwin(n, HS));
    cause(8'h80);
    k = $random(seed) & 7;
    wr(`RSR_ADDR_CFG, 32'(8'h1 << k));
    wr(`RSR_ADDR_CTRL, 32'h1);
    gpio_in <= 8'h1 << ((k + 1) % 8);
    repeat (10) still(1);
    gpio_in <= gpio_in ^ (8'h1 << k);
    rel(0);
    need(inwin(n, HS));
    cause(8'h40);
    rdr(`RSR_ADDR_CFG, rd);
    chk(rd & 32'hff, 32'(8'h1 << k));
    wr(`RSR_ADDR_CTRL, 32'h1);
    wdt_hit();
    rel(0);
    conclude();
  end
endmodule : rsr_controller_tb
